// ==== include/rxvf_pkg.sv ====
`default_nettype none
package rxvf_pkg;
  // Register offsets (byte addresses)
  localparam logic [11:0] AGG_OFS    = 12'h000;
  localparam logic [11:0] PART_OFS   = 12'h004;
  localparam logic [11:0] HALT_OFS   = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  // Field layout
  localparam int FIELD_W        = 2;
  localparam int STAT_BUSY_POS  = 8;
  // Reset values
  localparam logic [7:0] AGG_RST  = 8'h00;
  localparam logic [7:0] PART_RST = 8'h00;
  localparam logic [3:0] HALT_RST = 4'h0;
  // Aggregation codes
  localparam logic [1:0] AGG_32  = 2'h0;
  localparam logic [1:0] AGG_64  = 2'h1;
  localparam logic [1:0] AGG_128 = 2'h2;
  // Geometry and timing counts
  localparam int BANKS        = 4;
  localparam int FIFOS        = 8;
  localparam int BURST_WORDS  = 4;
  localparam int PAUSE_CYCLES = 2;
  localparam int PORT_W       = 8;
  // Write request from the protocol decoder
  typedef struct packed {
    logic [2:0]        fifo;
    logic              eop;
    logic [PORT_W-1:0] port;
    logic [31:0]       data;
  } rxvf_wr_t;
  // Stored word: data plus its control tag
  typedef struct packed {
    logic              eop;
    logic [PORT_W-1:0] port;
    logic [31:0]       data;
  } rxvf_word_t;
  // Read burst sequencer
  typedef enum logic [1:0] {
    ST_DATA  = 2'b00,
    ST_PORT  = 2'b01,
    ST_PAUSE = 2'b10
  } rxvf_state_t;
endpackage
`default_nettype wire

// ==== design/rxvf_top.sv ====
// The APB slave port and the placing of the registers were left to the implementer.
`default_nettype none
module rxvf_top #(
  parameter int BANK_WORDS = 512
) (
  // Clock and reset
  input  wire logic                                 SYS_CLK,
  input  wire logic                                 RST_N,
  // APB slave
  input  wire logic                                 PSEL,
  input  wire logic                                 PENABLE,
  input  wire logic                                 PWRITE,
  input  wire logic [11:0]                          PADDR,
  input  wire logic [31:0]                          PWDATA,
  output logic      [31:0]                          PRDATA,
  output logic                                      PREADY,
  output logic                                      PSLVERR,
  // Write side from the protocol decoder
  input  wire logic                                 WR_VALID,
  input  wire logic [1:0]                           WR_BANK,
  input  wire rxvf_pkg::rxvf_wr_t                   WR_REQ,
  output logic                                      WR_READY,
  // Fabric read ports, one per bank
  input  wire logic [rxvf_pkg::BANKS-1:0]           RX_RD_EN,
  input  wire logic [rxvf_pkg::BANKS-1:0][2:0]      RX_FIFO_SEL,
  output logic      [rxvf_pkg::BANKS-1:0][31:0]     RX_DATA,
  output logic      [rxvf_pkg::BANKS-1:0][3:0]      RX_WORD_BYTE_VALID,
  output logic      [rxvf_pkg::BANKS-1:0]           RX_EOP,
  output logic      [rxvf_pkg::BANKS-1:0]           RX_PORT_CYCLE
);
  localparam int NB = rxvf_pkg::BANKS;
  localparam int NF = rxvf_pkg::FIFOS;
  localparam int AW = $clog2(NB * BANK_WORDS);   // Flat memory address
  localparam int CW = AW + 1;                     // Counts reach full size

  // Bank size must be a power of two large enough for eight partitions
  if (BANK_WORDS < 8 || (BANK_WORDS & (BANK_WORDS - 1)) != 0) begin : g_chk
    $error("BANK_WORDS must be a power of two of at least 8");
  end

  // Software-visible control
  logic [7:0]       agg_r;                        // Two bits per bank
  logic [7:0]       part_r;                       // Two bits per bank
  logic [NB-1:0]    first_if_halt_after_packet_r; // Pause after packet end
  logic [31:0]      prdata_r;                     // Registered read data
  logic             slverr_r;                     // Unmapped in this access

  // Storage: one flat array, banks laid end to end so pairs are contiguous
  rxvf_pkg::rxvf_word_t mem [NB*BANK_WORDS];

  // Per-partition bookkeeping
  logic [CW-1:0] cnt_r    [NB][NF];   // Words held
  logic [CW-1:0] wr_ptr_r [NB][NF];   // Next write slot
  logic [CW-1:0] rd_ptr_r [NB][NF];   // Next read slot

  // Per-bank pop request from the burst sequencers
  logic [NB-1:0]      pop;
  logic [NB-1:0][2:0] pop_fifo;

  // Aggregation code of a bank
  function automatic logic [1:0] agg_of(input logic [1:0] b, input logic [7:0] a);
    agg_of = a[{b, 1'b0} +: 2];
  endfunction

  // Bank that owns a bank's storage under aggregation
  function automatic logic [1:0] lead_of(input logic [1:0] b, input logic [1:0] ag);
    case (ag)
      rxvf_pkg::AGG_64:  lead_of = {b[1], 1'b0};
      rxvf_pkg::AGG_128: lead_of = 2'h0;
      default:           lead_of = b;
    endcase
  endfunction

  // Words per partition: bank size, scaled by aggregation, split by count
  function automatic logic [CW-1:0] depth_of(input logic [1:0] ag, input logic [1:0] pc);
    logic [CW-1:0] base;
    base = CW'(BANK_WORDS);
    case (ag)
      rxvf_pkg::AGG_64:  base = base << 1;
      rxvf_pkg::AGG_128: base = base << 2;
      default:           base = base;
    endcase
    depth_of = base >> pc;
  endfunction

  // Partition index from a read or write address, valid flag on top
  function automatic logic [3:0] sel_of(input logic [2:0] a, input logic [1:0] pc);
    logic [2:0] mask;
    mask = 3'(({1'b0, 3'h7} >> (3 - pc)) & 4'h7);
    if (pc == 2'h0) begin
      sel_of = 4'h8;
    end else if ((a & ~mask) != 3'h0) begin
      sel_of = 4'h0;
    end else begin
      sel_of = {1'b1, a};
    end
  endfunction

  // Flat address of a slot
  function automatic logic [AW-1:0] addr_of(input logic [1:0] ld, input logic [2:0] f,
                                            input logic [CW-1:0] d, input logic [CW-1:0] p);
    logic [2*CW-1:0] sum;
    sum = (2*CW)'(ld) * (2*CW)'(BANK_WORDS) + (2*CW)'(f) * (2*CW)'(d) + (2*CW)'(p);
    addr_of = sum[AW-1:0];
  endfunction

  // Next pointer value with wrap at partition depth
  function automatic logic [CW-1:0] step(input logic [CW-1:0] p, input logic [CW-1:0] d);
    step = (p == d - 1'b1) ? '0 : p + 1'b1;
  endfunction

  // APB: zero wait states, error on unmapped offsets
  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_r;
  assign PSLVERR = slverr_r & PSEL & PENABLE;

  // Address decode for the access in progress
  logic apb_hit;
  assign apb_hit = (PADDR == rxvf_pkg::AGG_OFS)  || (PADDR == rxvf_pkg::PART_OFS) ||
                   (PADDR == rxvf_pkg::HALT_OFS) || (PADDR == rxvf_pkg::STATUS_OFS);

  // Configuration registers, written at the access edge
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      agg_r                        <= rxvf_pkg::AGG_RST;
      part_r                       <= rxvf_pkg::PART_RST;
      first_if_halt_after_packet_r <= rxvf_pkg::HALT_RST;
    end else if (PSEL && PENABLE && PWRITE) begin
      case (PADDR)
        rxvf_pkg::AGG_OFS:  agg_r  <= PWDATA[7:0];
        rxvf_pkg::PART_OFS: part_r <= PWDATA[7:0];
        rxvf_pkg::HALT_OFS: first_if_halt_after_packet_r <= PWDATA[NB-1:0];
        default: ;                                                       // Read-only or unmapped
      endcase
    end
  end

  // Status: bit b shows bank b holds data, busy bits show a burst open
  logic [NB-1:0] bank_has_data;
  logic [NB-1:0] bank_busy;
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      bank_has_data[b] = 1'b0;
      for (int f = 0; f < NF; f++) begin
        if (cnt_r[b][f] != '0) begin
          bank_has_data[b] = 1'b1;
        end
      end
    end
  end

  // Read data captured in the setup cycle, steady through the access
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      slverr_r <= !apb_hit;
      case (PADDR)
        rxvf_pkg::AGG_OFS:    prdata_r <= {24'h000000, agg_r};
        rxvf_pkg::PART_OFS:   prdata_r <= {24'h000000, part_r};
        rxvf_pkg::HALT_OFS:   prdata_r <= {28'h0000000, first_if_halt_after_packet_r};
        rxvf_pkg::STATUS_OFS: prdata_r <= {20'h00000, bank_busy, 4'h0, bank_has_data};
        default:              prdata_r <= 32'h00000000;
      endcase
    end
  end

  // Write side decode: target partition of the incoming word
  logic [1:0]    wr_agg;
  logic [1:0]    wr_lead;
  logic [3:0]    wr_sel;
  logic [CW-1:0] wr_depth;
  logic          wr_push;
  assign wr_agg   = agg_of(WR_BANK, agg_r);
  assign wr_lead  = lead_of(WR_BANK, wr_agg);
  assign wr_sel   = sel_of(WR_REQ.fifo, part_r[{wr_lead, 1'b0} +: 2]);
  assign wr_depth = depth_of(wr_agg, part_r[{wr_lead, 1'b0} +: 2]);
  // Words aimed at a partition that does not exist are taken and dropped
  assign WR_READY = (wr_sel[3] == 1'b0) || (cnt_r[wr_lead][wr_sel[2:0]] != wr_depth);
  assign wr_push  = WR_VALID && WR_READY && wr_sel[3];

  // Memory write port
  always_ff @(posedge SYS_CLK) begin
    if (wr_push) begin
      mem[addr_of(wr_lead, wr_sel[2:0], wr_depth, wr_ptr_r[wr_lead][wr_sel[2:0]])] <=
        '{eop: WR_REQ.eop, port: WR_REQ.port, data: WR_REQ.data};
    end
  end

  // Counts: push and pop in one cycle leave the count unchanged
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (int b = 0; b < NB; b++) begin
        for (int f = 0; f < NF; f++) begin
          cnt_r[b][f] <= '0;
        end
      end
    end else begin
      for (int b = 0; b < NB; b++) begin
        for (int f = 0; f < NF; f++) begin
          cnt_r[b][f] <= cnt_r[b][f]
                       + CW'(wr_push && wr_lead == 2'(b) && wr_sel[2:0] == 3'(f))
                       - CW'(pop[b] && pop_fifo[b] == 3'(f));
        end
      end
    end
  end

  // Write pointers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (int b = 0; b < NB; b++) begin
        for (int f = 0; f < NF; f++) begin
          wr_ptr_r[b][f] <= '0;
        end
      end
    end else if (wr_push) begin
      wr_ptr_r[wr_lead][wr_sel[2:0]] <= step(wr_ptr_r[wr_lead][wr_sel[2:0]], wr_depth);
    end
  end

  // Read pointers, one pop per bank per cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (int b = 0; b < NB; b++) begin
        for (int f = 0; f < NF; f++) begin
          rd_ptr_r[b][f] <= '0;
        end
      end
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (pop[b]) begin
          rd_ptr_r[b][pop_fifo[b]] <= step(rd_ptr_r[b][pop_fifo[b]],
                                           depth_of(agg_of(2'(b), agg_r), part_r[2*b +: 2]));
        end
      end
    end
  end

  // One burst sequencer per bank, each on its own read enable
  for (genvar gb = 0; gb < NB; gb++) begin : g_bank
    rxvf_pkg::rxvf_state_t state_r;   // Burst phase
    logic [1:0]            beat_r;    // Words sent in this burst
    logic [1:0]            pause_r;   // Pause cycles left
    logic [rxvf_pkg::PORT_W-1:0] port_r; // Port of the last word
    logic [31:0]           data_r;
    logic [3:0]            be_r;
    logic                  eop_r;
    logic                  pcyc_r;
    logic [1:0]            agg;
    logic                  is_lead;
    logic [3:0]            sel;
    logic [CW-1:0]         depth;
    rxvf_pkg::rxvf_word_t  word;

    assign agg     = agg_of(2'(gb), agg_r);
    // Only the bank that names a combined buffer reads it
    assign is_lead = (lead_of(2'(gb), agg) == 2'(gb));
    assign sel     = sel_of(RX_FIFO_SEL[gb], part_r[2*gb +: 2]);
    assign depth   = depth_of(agg, part_r[2*gb +: 2]);
    // Empty or absent partition: no pop, so enables stay low
    assign pop[gb] = is_lead && state_r == rxvf_pkg::ST_DATA && RX_RD_EN[gb] && sel[3]
                     && cnt_r[gb][sel[2:0]] != '0;
    assign pop_fifo[gb] = sel[2:0];
    assign word = mem[addr_of(2'(gb), sel[2:0], depth, rd_ptr_r[gb][sel[2:0]])];
    assign bank_busy[gb] = (state_r != rxvf_pkg::ST_DATA) || (beat_r != 2'h0);

    // Burst phase sequencing
    always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
        state_r <= rxvf_pkg::ST_DATA;
        beat_r  <= 2'h0;
        pause_r <= 2'h0;
      end else begin
        case (state_r)
          rxvf_pkg::ST_DATA: begin
            if (pop[gb]) begin
              if (word.eop && first_if_halt_after_packet_r[gb]) begin
                state_r <= rxvf_pkg::ST_PAUSE;
                pause_r <= 2'(rxvf_pkg::PAUSE_CYCLES - 1);
              end else if (word.eop || beat_r == 2'(rxvf_pkg::BURST_WORDS - 1)) begin
                state_r <= rxvf_pkg::ST_PORT;
              end
              beat_r <= beat_r + 2'h1;
            end
          end
          rxvf_pkg::ST_PAUSE: begin
            if (pause_r == 2'h0) begin
              state_r <= rxvf_pkg::ST_PORT;
            end
            pause_r <= pause_r - 2'h1;
          end
          rxvf_pkg::ST_PORT: begin
            // Early end drops the rest; next burst starts straight away
            state_r <= rxvf_pkg::ST_DATA;
            beat_r  <= 2'h0;
          end
          default: begin
            state_r <= rxvf_pkg::ST_DATA;
            beat_r  <= 2'h0;
          end
        endcase
      end
    end

    // Output word, port-id cycle or idle
    always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
        data_r <= 32'h00000000;
        be_r   <= 4'h0;
        eop_r  <= 1'b0;
        pcyc_r <= 1'b0;
        port_r <= '0;
      end else if (pop[gb]) begin
        data_r <= word.data;
        be_r   <= 4'hf;
        eop_r  <= word.eop;
        pcyc_r <= 1'b0;
        port_r <= word.port;
      end else if (state_r == rxvf_pkg::ST_PORT) begin
        data_r <= {{(32 - rxvf_pkg::PORT_W){1'b0}}, port_r};
        be_r   <= 4'hf;
        eop_r  <= 1'b0;
        pcyc_r <= 1'b1;
      end else begin
        // Pause, stall or empty: data marked invalid
        be_r   <= 4'h0;
        eop_r  <= 1'b0;
        pcyc_r <= 1'b0;
      end
    end

    assign RX_DATA[gb]            = data_r;
    assign RX_WORD_BYTE_VALID[gb] = be_r;
    assign RX_EOP[gb]             = eop_r;
    assign RX_PORT_CYCLE[gb]      = pcyc_r;
  end

endmodule
`default_nettype wire

// ==== verification/rxvf_chk.sv ====
`default_nettype none
module rxvf_chk (
  // Clock and reset
  input wire logic                                 SYS_CLK,
  input wire logic                                 RST_N,
  // Read ports
  input wire logic [rxvf_pkg::BANKS-1:0]           RX_RD_EN,
  input wire logic [rxvf_pkg::BANKS-1:0][3:0]      RX_WORD_BYTE_VALID,
  input wire logic [rxvf_pkg::BANKS-1:0]           RX_EOP,
  input wire logic [rxvf_pkg::BANKS-1:0]           RX_PORT_CYCLE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic [2:0] words_r;  // Bank 0 data words since the last port-id cycle
  wire logic  dval = RX_WORD_BYTE_VALID[0] == 4'hf && !RX_PORT_CYCLE[0];  // Data word shown
  // Burst length count; port-id cycle restarts it
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || RX_PORT_CYCLE[0]) words_r <= 3'h0;
    else if (dval) words_r <= words_r + 3'h1;
  end
  property p_burst_len; words_r <= 3'h4; endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst longer than four words");
  property p_port_be; RX_PORT_CYCLE[0] |-> RX_WORD_BYTE_VALID[0] == 4'hf; endproperty
  a_port_be: assert property (p_port_be) else $error("port cycle not marked valid");
  property p_port_gap; RX_PORT_CYCLE[0] |=> !RX_PORT_CYCLE[0]; endproperty
  a_port_gap: assert property (p_port_gap) else $error("two port cycles in a row");
  property p_eop_word; RX_EOP[0] |-> dval; endproperty
  a_eop_word: assert property (p_eop_word) else $error("end flag without a data word");
  property p_eop_end; RX_EOP[0] |-> ##[1:3] RX_PORT_CYCLE[0]; endproperty
  a_eop_end: assert property (p_eop_end) else $error("burst not closed after end of packet");
  property p_pause; RX_EOP[0] ##1 !RX_PORT_CYCLE[0] |-> (RX_WORD_BYTE_VALID[0] == 4'h0) [*2] ##1 RX_PORT_CYCLE[0];
  endproperty
  a_pause: assert property (p_pause) else $error("pause after end of packet wrong");
  property p_be_code; RX_WORD_BYTE_VALID[0] == 4'h0 || RX_WORD_BYTE_VALID[0] == 4'hf; endproperty
  a_be_code: assert property (p_be_code) else $error("partial byte enables");
  property p_pop_cause; dval |-> $past(RX_RD_EN[0]); endproperty
  a_pop_cause: assert property (p_pop_cause) else $error("word without read enable");
endmodule
bind rxvf_top rxvf_chk rxvf_chk_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RX_RD_EN(RX_RD_EN),
  .RX_WORD_BYTE_VALID(RX_WORD_BYTE_VALID), .RX_EOP(RX_EOP), .RX_PORT_CYCLE(RX_PORT_CYCLE));
`default_nettype wire

// ==== verification/rxvf_reader.sv ====
`default_nettype none
module rxvf_reader (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bench control
  input  wire logic        run,
  input  wire logic        slow,
  // Bank read port
  input  wire logic [31:0] data,
  input  wire logic [3:0]  be,
  input  wire logic        eop,
  input  wire logic        port_cyc,
  output logic             rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tog_r;   // Alternates so a slow reader asks every other cycle
  logic [33:0] got[$];  // Port flag, end flag, data of each valid cycle
  // Request pacing
  always_ff @(posedge clk) begin
    tog_r <= rst_n ? !tog_r : 1'b0;
    rd_en <= rst_n && run && (!slow || tog_r);
  end
  // Capture; end flag masked in port cycles since only the word carries it
  always @(posedge clk)
    if (be == 4'hf) got.push_back({port_cyc, eop && !port_cyc, data});
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, seq;
  logic               wr_valid, wr_ready, run, slow, rdr_en;
  logic [1:0]         wr_bank;
  rxvf_pkg::rxvf_wr_t wr_req;
  logic [3:1]         rd_hi;  // Bench enables for banks 1 to 3
  logic [3:0][2:0]    sel;
  logic [3:0][31:0]   rx_data;
  logic [3:0][3:0]    rx_be;
  logic [3:0]         rx_eop, rx_pc;
  logic [33:0]        exp_q[$];
  int                 err_total, checks_done, cyc, seen1;
  rxvf_top #(.BANK_WORDS(16)) rxvf_top_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WR_VALID(wr_valid), .WR_BANK(wr_bank), .WR_REQ(wr_req),
    .WR_READY(wr_ready), .RX_RD_EN({rd_hi, rdr_en}), .RX_FIFO_SEL(sel), .RX_DATA(rx_data),
    .RX_WORD_BYTE_VALID(rx_be), .RX_EOP(rx_eop), .RX_PORT_CYCLE(rx_pc));
  rxvf_reader rxvf_reader_inst (.clk(sys_clk), .rst_n(rst_n), .run(run), .slow(slow),
    .data(rx_data[0]), .be(rx_be[0]), .eop(rx_eop[0]), .port_cyc(rx_pc[0]), .rd_en(rdr_en));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = !sys_clk;
  end
  // Hang guard and bank 1 watcher
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_be[1] == 4'hf) seen1++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    sel <= '0;
    rd_hi <= '0;
    wr_bank <= 2'h0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rxvf_reader_inst.got.delete();
    exp_q.delete();
    @(posedge sys_clk);
  endtask
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Push one packet into bank 0 and predict the burst pattern
  task automatic pkt(input logic [2:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_req <= '{fifo: f, eop: (i == n - 1), port: 8'h5a, data: seq};
      do @(posedge sys_clk); while (wr_ready !== 1'b1);
      exp_q.push_back({1'b0, i == n - 1, seq});
      if (i % 4 == 3 || i == n - 1) exp_q.push_back({2'b10, 24'h0, 8'h5a});
      seq++;
    end
    wr_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic drain(input logic s);
    slow <= s;
    run <= 1'b1;
    for (int k = 0; k < 300 && rxvf_reader_inst.got.size() < exp_q.size(); k++) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    run <= 1'b0;
    chk(rxvf_reader_inst.got.size(), exp_q.size());
    foreach (exp_q[i]) chk(rxvf_reader_inst.got[i], exp_q[i]);
  endtask
  task automatic t_regs();
    logic [32:0] q;
    reset_dut();
    apb(1'b0, rxvf_pkg::AGG_OFS, 32'h0, q);
    chk(q, {25'h0, rxvf_pkg::AGG_RST});
    apb(1'b0, rxvf_pkg::HALT_OFS, 32'h0, q);
    chk(q, {29'h0, rxvf_pkg::HALT_RST});
    apb(1'b1, rxvf_pkg::PART_OFS, 32'hffff_ffe4, q);
    apb(1'b0, rxvf_pkg::PART_OFS, 32'h0, q);
    chk(q, 33'h0_0000_00e4);
    apb(1'b0, 12'h010, 32'h0, q);
    chk(q, 33'h1_0000_0000);
    $display("regs test done");
  endtask
  // Address ignored with one partition; early end closes the burst
  task automatic t_burst();
    logic [32:0] q;
    reset_dut();
    sel[0] <= 3'h7;
    pkt(3'h0, 6);
    pkt(3'h0, 2);
    // Stored words show as bank 0 holding data, no burst open yet
    apb(1'b0, rxvf_pkg::STATUS_OFS, 32'h0, q);
    chk(q, 33'h0_0000_0001);
    drain(1'b0);
    $display("burst test done");
  endtask
  task automatic t_halt();
    logic [32:0] q;
    reset_dut();
    apb(1'b1, rxvf_pkg::HALT_OFS, 32'h1, q);
    pkt(3'h0, 2);
    pkt(3'h0, 5);
    drain(1'b1);
    $display("halt test done");
  endtask
  // Eight partitions: an empty one yields nothing
  task automatic t_addr();
    logic [32:0] q;
    reset_dut();
    apb(1'b1, rxvf_pkg::PART_OFS, 32'h3, q);
    // Eight partitions leave two words each, so the packet fits exactly
    pkt(3'h5, 2);
    sel[0] <= 3'h4;
    run <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(rxvf_reader_inst.got.size(), 0);
    sel[0] <= 3'h5;
    drain(1'b0);
    $display("addr test done");
  endtask
  // Pair 0/1 in 64-bit: bank 1 writes land in lead bank 0
  task automatic t_agg();
    logic [32:0] q;
    reset_dut();
    apb(1'b1, rxvf_pkg::AGG_OFS, 32'h5, q);
    wr_bank <= 2'h1;
    rd_hi[1] <= 1'b1;
    seen1 = 0;
    pkt(3'h0, 3);
    drain(1'b0);
    chk(seen1, 0);
    $display("agg test done");
  endtask
  // Capacity per partition: {agg, part, words}
  task automatic t_depth();
    logic [32:0] q;
    logic [23:0] cfg[5] = '{24'h000010, 24'h005508, 24'h00ff02, 24'h055510, 24'haaaa10};
    int          n;
    foreach (cfg[i]) begin
      reset_dut();
      apb(1'b1, rxvf_pkg::AGG_OFS, {24'h0, cfg[i][23:16]}, q);
      apb(1'b1, rxvf_pkg::PART_OFS, {24'h0, cfg[i][15:8]}, q);
      n = 0;
      wr_valid <= 1'b1;
      repeat (80) begin
        @(posedge sys_clk);
        n += (wr_ready === 1'b1);
      end
      wr_valid <= 1'b0;
      chk(n, cfg[i][7:0]);
    end
    $display("depth test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, wr_valid, run, slow} = '0;
    {paddr, pwdata, wr_req, seq} = '0;
    {wr_bank, rd_hi, sel} = '0;
    t_regs();
    t_burst();
    t_halt();
    t_addr();
    t_agg();
    t_depth();
    finish_test();
  end
endmodule
`default_nettype wire
